// ---- logic/clp_pkg.sv ----
// Constants and types shared by the current-limit PWM timing block
package clp_pkg;

  // ==========================================================
  // Clock and time base
  localparam int CLK_PERIOD_NS  = 25;
  localparam int TICK_NS        = 400;
  localparam int TICK_CYCLES    = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRE_W          = $clog2(TICK_CYCLES);

  // ==========================================================
  // Off-time and blank timing, in ticks of TICK_NS
  localparam int OFF_BASE_NS    = 20000;
  localparam int OFF_STEP_NS    = 1600;
  localparam int OFF_BASE_TICKS = OFF_BASE_NS / TICK_NS;
  localparam int OFF_STEP_TICKS = OFF_STEP_NS / TICK_NS;
  localparam int OFF_TICK_W     = 8;

  // ==========================================================
  // Field widths
  localparam int OFF_CODE_W     = 5;
  localparam int THR_CODE_W     = 4;
  localparam int BLANK_CODE_W   = 4;
  localparam int DUTY_W         = 8;
  localparam int DUTY_CNT_W     = 16;

  // ==========================================================
  // Reset values
  localparam logic [3:0] THR_RST   = 4'h0;
  localparam logic [7:0] DUTY_RST  = 8'h00;

  // ==========================================================
  // Recirculation select encodings
  localparam logic [1:0] RECIRC_AUTO = 2'h0;
  localparam logic [1:0] RECIRC_HIGH = 2'h1;
  localparam logic [1:0] RECIRC_LOW  = 2'h2;
  localparam logic [1:0] RECIRC_FAST = 2'h3;

  // ==========================================================
  // Control modes and bridge phase states
  typedef enum logic [1:0] {
    MODE_DIRECT   = 2'h0,
    MODE_INDIRECT = 2'h1,
    MODE_SPEED    = 2'h2,
    MODE_CURRENT  = 2'h3
  } clp_ctl_mode_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_DRIVE = 2'h1,
    ST_OFF   = 2'h3
  } clp_state_type;

endpackage

// ---- logic/clp_duty_if.sv ----
// Link between the timing core and the PWM duty meter
`timescale 1ns/1ps
interface clp_duty_if;
  logic       pwm_level;
  logic [7:0] duty_code;

  modport meter (
    input  pwm_level,
    output duty_code
  );
  modport user (
    output pwm_level,
    input  duty_code
  );
endinterface

// ---- logic/clp_duty_meter.sv ----
// PWM input duty-cycle meter with 8-bit result
`timescale 1ns/1ps
module clp_duty_meter #(
  parameter int CNT_W = clp_pkg::DUTY_CNT_W
) (
  // Clock and reset
  input  wire logic   ref_clk_i,
  input  wire logic   rst_b_i,
  // Synchronised PWM level in, duty out
  clp_duty_if.meter   duty_bus
);

  logic             prev;
  logic [CNT_W-1:0] hi_cnt;
  logic [CNT_W-1:0] per_cnt;
  logic [CNT_W-1:0] per_lat;
  logic [CNT_W:0]   rem;
  logic [7:0]       quo;
  logic [3:0]       bits_left;
  logic [7:0]       duty;
  logic             next_prev;
  logic [CNT_W-1:0] next_hi_cnt;
  logic [CNT_W-1:0] next_per_cnt;
  logic [CNT_W-1:0] next_per_lat;
  logic [CNT_W:0]   next_rem;
  logic [7:0]       next_quo;
  logic [3:0]       next_bits_left;
  logic [7:0]       next_duty;

  // ==========================================================
  // Period capture and serial divide, one quotient bit a cycle
  always_comb begin
    logic [CNT_W:0] shifted;
    shifted        = '0;
    next_prev      = duty_bus.pwm_level;
    next_hi_cnt    = hi_cnt;
    next_per_cnt   = per_cnt;
    next_per_lat   = per_lat;
    next_rem       = rem;
    next_quo       = quo;
    next_bits_left = bits_left;
    next_duty      = duty;
    if (duty_bus.pwm_level && !prev) begin
      if (per_cnt != '0 && bits_left == 4'h0) begin
        next_per_lat   = per_cnt;
        next_rem       = {1'b0, hi_cnt};
        next_quo       = 8'h00;
        next_bits_left = 4'h8;
      end
      next_per_cnt = CNT_W'(1);
      next_hi_cnt  = CNT_W'(1);
    end else if (per_cnt == '1) begin
      // Stuck input: no edges means 0 % or 100 %
      next_duty    = duty_bus.pwm_level ? 8'hFF : 8'h00;
      next_per_cnt = '0;
      next_hi_cnt  = '0;
    end else begin
      next_per_cnt = per_cnt + CNT_W'(1);
      next_hi_cnt  = hi_cnt + CNT_W'(duty_bus.pwm_level);
    end
    if (bits_left != 4'h0) begin
      shifted = {rem[CNT_W-1:0], 1'b0};
      if (shifted >= {1'b0, per_lat}) begin
        next_rem = shifted - {1'b0, per_lat};
        next_quo = {quo[6:0], 1'b1};
      end else begin
        next_rem = shifted;
        next_quo = {quo[6:0], 1'b0};
      end
      next_bits_left = bits_left - 4'h1;
      if (bits_left == 4'h1) begin
        next_duty = next_quo;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      prev      <= 1'b0;
      hi_cnt    <= '0;
      per_cnt   <= '0;
      per_lat   <= '0;
      rem       <= '0;
      quo       <= 8'h00;
      bits_left <= 4'h0;
      duty      <= clp_pkg::DUTY_RST;
    end else begin
      prev      <= next_prev;
      hi_cnt    <= next_hi_cnt;
      per_cnt   <= next_per_cnt;
      per_lat   <= next_per_lat;
      rem       <= next_rem;
      quo       <= next_quo;
      bits_left <= next_bits_left;
      duty      <= next_duty;
    end
  end

  assign duty_bus.duty_code = duty;

endmodule

// ---- logic/clp_current_limit.sv ----
// Bridge current-limit PWM timing: threshold, drive, off-time, blanking
//
// How it works
// - Closed-loop current mode: in current limit only the off-time sets the frequency.
// - Closed-loop current mode: threshold equals duty ratio times maximum threshold.
// - Duty measured to 8 bits; upper 4 bits replace the threshold code.
// - Other modes: threshold is (code+1) steps of 12.5 mV.
// - Each PWM cycle starts by switching the bridge into drive.
// - Comparator trip moves bridge to recirculation for the off-time.
// - Select 01 high-side slow, 10 low-side slow, 11 fast decay.
// - Select 00 default: slow decay, side chosen from back-emf direction.
// - Off-time is 20 us plus code times 1.6 us from the clock.
// - Indirect and speed modes: off-time value is the fixed period and off-time.
// - Comparator ignored for the blank time after drive turns on.
// - Blank time is code times 400 ns from the clock.
// - Same blank masks the drain-source monitors after each switching action.
// - Auto mode: falling emf low-side then high-side; rising the reverse.
// - Direct voltage mode: PWM input pin sets the bridge frequency.
`timescale 1ns/1ps
module clp_current_limit (
  // Clock and reset
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_b_i,
  // Configuration
  input  wire clp_pkg::clp_ctl_mode_type   control_mode_i,
  input  wire logic [4:0]                  off_time_code_i,
  input  wire logic [3:0]                  current_threshold_code_i,
  input  wire logic [1:0]                  recirculation_select_i,
  input  wire logic [3:0]                  blank_time_code_i,
  // Commutation controller
  input  wire logic                        bemf_falling_i,
  input  wire logic                        zero_cross_seen_i,
  // Pins
  input  wire logic                        pwm_in_i,
  input  wire logic                        sense_cmp_i,
  input  wire logic                        ds_monitor_i,
  // Threshold and bridge control
  output logic [3:0]                       current_limit_threshold_o,
  output logic                             drive_o,
  output logic                             recirc_high_side_o,
  output logic                             recirc_low_side_o,
  output logic                             fast_decay_o,
  output logic                             limit_active_o,
  output logic                             blank_o,
  output logic                             ds_fault_o
);

  clp_duty_if duty_bus ();

  logic                   pwm_m;
  logic                   pwm_s;
  logic                   cmp_m;
  logic                   cmp_s;
  logic                   ds_m;
  logic                   ds_s;
  clp_pkg::clp_state_type state;
  clp_pkg::clp_state_type next_state;
  logic [clp_pkg::PRE_W-1:0] pre;
  logic [clp_pkg::PRE_W-1:0] next_pre;
  logic [7:0]             off_cnt;
  logic [7:0]             next_off_cnt;
  logic [7:0]             per_cnt;
  logic [7:0]             next_per_cnt;
  logic [3:0]             blank_cnt;
  logic [3:0]             next_blank_cnt;
  logic [7:0]             off_load;
  logic                   tick;
  logic                   trip;
  logic                   fixed_mode;
  logic                   mode_cur;
  logic                   mode_dir;
  logic                   off_expire;
  logic                   per_expire;
  logic                   start_drive;
  logic                   switch_evt;
  logic                   next_hs;
  logic                   next_ls;
  logic                   next_fast;
  logic [3:0]             next_thr;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      pwm_m <= 1'b0;
      pwm_s <= 1'b0;
      cmp_m <= 1'b0;
      cmp_s <= 1'b0;
      ds_m  <= 1'b0;
      ds_s  <= 1'b0;
    end else begin
      pwm_m <= pwm_in_i;
      pwm_s <= pwm_m;
      cmp_m <= sense_cmp_i;
      cmp_s <= cmp_m;
      ds_m  <= ds_monitor_i;
      ds_s  <= ds_m;
    end
  end

  assign duty_bus.pwm_level = pwm_s;

  clp_duty_meter #(
    .CNT_W (clp_pkg::DUTY_CNT_W)
  ) u_duty (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .duty_bus  (duty_bus.meter)
  );

  // ==========================================================
  // Mode decode and timing terms
  assign mode_cur   = control_mode_i == clp_pkg::MODE_CURRENT;
  assign mode_dir   = control_mode_i == clp_pkg::MODE_DIRECT;
  assign fixed_mode = control_mode_i == clp_pkg::MODE_INDIRECT ||
                      control_mode_i == clp_pkg::MODE_SPEED;
  assign tick       = pre == clp_pkg::PRE_W'(clp_pkg::TICK_CYCLES - 1);
  // Base 50 ticks, 4 ticks a step; code zero adds nothing
  assign off_load   = 8'(clp_pkg::OFF_BASE_TICKS +
                         clp_pkg::OFF_STEP_TICKS * int'(off_time_code_i));
  // Blanking gates the comparator only while driving; its length is software's duty
  assign trip       = state == clp_pkg::ST_DRIVE && cmp_s &&
                      blank_cnt == 4'h0;
  assign off_expire = tick && off_cnt == 8'h01;
  assign per_expire = tick && per_cnt == 8'h01;

  // ==========================================================
  // Bridge phase state machine
  always_comb begin
    next_state = state;
    case (state)
      clp_pkg::ST_IDLE: begin
        if (!mode_dir || pwm_s) begin
          next_state = clp_pkg::ST_DRIVE;
        end
      end
      clp_pkg::ST_DRIVE: begin
        if (trip) begin
          next_state = clp_pkg::ST_OFF;
        end else if (mode_dir && !pwm_s) begin
          next_state = clp_pkg::ST_IDLE;
        end
      end
      clp_pkg::ST_OFF: begin
        if (off_expire) begin
          next_state = (mode_dir && !pwm_s) ? clp_pkg::ST_IDLE :
                                              clp_pkg::ST_DRIVE;
        end
      end
      default: begin
        next_state = clp_pkg::ST_IDLE;
      end
    endcase
  end

  // Fixed-frequency modes restart drive at a period end reached while driving; the
  // current mode has no period, so only the off-time paces it
  assign start_drive = next_state == clp_pkg::ST_DRIVE &&
                       (state != clp_pkg::ST_DRIVE ||
                        (fixed_mode && per_expire));
  assign switch_evt  = next_state != state || start_drive;

  // ==========================================================
  // Prescaler, off-time, period and blank counters
  always_comb begin
    next_pre       = tick ? '0 : pre + clp_pkg::PRE_W'(1);
    next_off_cnt   = off_cnt;
    next_per_cnt   = per_cnt;
    next_blank_cnt = blank_cnt;
    if (tick && off_cnt != 8'h00) begin
      next_off_cnt = off_cnt - 8'h01;
    end
    if (tick && per_cnt != 8'h00) begin
      next_per_cnt = per_cnt - 8'h01;
    end
    if (tick && blank_cnt != 4'h0) begin
      next_blank_cnt = blank_cnt - 4'h1;
    end
    if (switch_evt) begin
      // Restarting the prescaler keeps each phase an exact tick count
      next_pre       = '0;
      next_blank_cnt = blank_time_code_i;
    end
    if (start_drive) begin
      next_per_cnt = off_load;
    end
    if (next_state == clp_pkg::ST_OFF && state != clp_pkg::ST_OFF) begin
      next_off_cnt = off_load;
    end
  end

  // ==========================================================
  // Recirculation path and threshold selection
  always_comb begin
    next_hs   = 1'b0;
    next_ls   = 1'b0;
    next_fast = 1'b0;
    case (recirculation_select_i)
      clp_pkg::RECIRC_HIGH: next_hs   = 1'b1;
      clp_pkg::RECIRC_LOW:  next_ls   = 1'b1;
      clp_pkg::RECIRC_FAST: next_fast = 1'b1;
      default: begin
        next_hs = bemf_falling_i ? zero_cross_seen_i : !zero_cross_seen_i;
        next_ls = !next_hs;
      end
    endcase
    if (next_state == clp_pkg::ST_DRIVE) begin
      next_hs   = 1'b0;
      next_ls   = 1'b0;
      next_fast = 1'b0;
    end
    // Duty high nibble picks (n+1)/16 of full scale
    next_thr = mode_cur ? duty_bus.duty_code[7:4] :
                          current_threshold_code_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      state                     <= clp_pkg::ST_IDLE;
      pre                       <= '0;
      off_cnt                   <= 8'h00;
      per_cnt                   <= 8'h00;
      blank_cnt                 <= 4'h0;
      current_limit_threshold_o <= clp_pkg::THR_RST;
      drive_o                   <= 1'b0;
      recirc_high_side_o        <= 1'b0;
      recirc_low_side_o         <= 1'b0;
      fast_decay_o              <= 1'b0;
      limit_active_o            <= 1'b0;
      blank_o                   <= 1'b0;
      ds_fault_o                <= 1'b0;
    end else begin
      state                     <= next_state;
      pre                       <= next_pre;
      off_cnt                   <= next_off_cnt;
      per_cnt                   <= next_per_cnt;
      blank_cnt                 <= next_blank_cnt;
      current_limit_threshold_o <= next_thr;
      drive_o                   <= next_state == clp_pkg::ST_DRIVE;
      recirc_high_side_o        <= next_hs;
      recirc_low_side_o         <= next_ls;
      fast_decay_o              <= next_fast;
      limit_active_o            <= next_state == clp_pkg::ST_OFF;
      blank_o                   <= next_blank_cnt != 4'h0;
      ds_fault_o                <= ds_s && next_blank_cnt == 4'h0;
    end
  end

  // ==========================================================
  // Checks
  logic [11:0] off_cyc;
  logic [7:0]  off_held;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      off_cyc  <= 12'h000;
      off_held <= 8'h00;
    end else if (state != clp_pkg::ST_OFF) begin
      off_cyc  <= 12'h000;
      off_held <= off_load;
    end else begin
      off_cyc  <= off_cyc + 12'h001;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence trip_seq;
    state == clp_pkg::ST_DRIVE && cmp_s && blank_cnt == 4'h0;
  endsequence

  sequence off_entered_seq;
    state == clp_pkg::ST_OFF && limit_active_o && !drive_o;
  endsequence

  thr_source_a: assert property (1'b1 |=> current_limit_threshold_o ==
    ($past(mode_cur) ? $past(duty_bus.duty_code[7:4]) : $past(current_threshold_code_i)))
    else $error("threshold code not taken from the selected source");

  trip_off_a: assert property (trip_seq |=> off_entered_seq)
    else $error("comparator trip did not start the off-time");

  blank_hold_a: assert property ((state == clp_pkg::ST_DRIVE &&
    blank_cnt != 4'h0) |=> state != clp_pkg::ST_OFF)
    else $error("trip taken during blanking");

  off_length_a: assert property ((state == clp_pkg::ST_OFF && off_expire)
    |-> off_cyc == 12'(off_held) * 12'(clp_pkg::TICK_CYCLES) - 12'h001)
    else $error("off-time length wrong");

  off_zero_a: assert property ((state != clp_pkg::ST_OFF && trip &&
    off_time_code_i == 5'h00) |=> off_cnt == 8'(clp_pkg::OFF_BASE_TICKS))
    else $error("zero code did not give base off-time");

  blank_load_a: assert property (start_drive |=>
    blank_cnt == $past(blank_time_code_i) && blank_o == ($past(blank_time_code_i) != 4'h0))
    else $error("blank period not loaded at drive start");

  ds_mask_a: assert property (blank_o |-> !ds_fault_o)
    else $error("drain-source monitor not masked during blank");

  auto_mix_a: assert property ((next_state != clp_pkg::ST_DRIVE &&
    recirculation_select_i == clp_pkg::RECIRC_AUTO && bemf_falling_i &&
    !zero_cross_seen_i) |=> recirc_low_side_o && !recirc_high_side_o)
    else $error("auto recirculation side wrong");

  redrive_a: assert property ((state == clp_pkg::ST_OFF && off_expire &&
    !mode_dir) |=> drive_o && state == clp_pkg::ST_DRIVE &&
    blank_cnt == $past(blank_time_code_i))
    else $error("drive not restarted after off-time");

  period_a: assert property ((state == clp_pkg::ST_DRIVE && !trip &&
    fixed_mode && per_expire) |=> per_cnt == $past(off_load) && drive_o)
    else $error("fixed period not restarted");

  direct_a: assert property ((state == clp_pkg::ST_DRIVE && mode_dir &&
    !pwm_s && !trip) |=> !drive_o && state == clp_pkg::ST_IDLE)
    else $error("direct mode drive not following pin");

endmodule

// ---- bench/clp_bridge_model.sv ----
// Behavioural bridge and current-sense comparator on the far side of the block
`timescale 1ns/1ps
// ====================
// Bridge model
module clp_bridge_model (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // Bridge control from the block
  input  wire logic        drive_i,
  input  wire logic        fast_decay_i,
  // Bench controls
  input  wire logic [15:0] trip_level_i,
  input  wire logic        short_i,
  // Comparator and monitor
  output logic             sense_cmp_o,
  output logic             ds_monitor_o
);
  logic [15:0] cur;

  // Current ramps in drive and decays otherwise; capped so a top level never trips
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      cur <= 16'h0000;
    end else if (drive_i) begin
      cur <= (cur == 16'hFFFE) ? cur : cur + 16'h0001;
    end else if (cur > 16'h0001) begin
      cur <= cur - (fast_decay_i ? 16'h0002 : 16'h0001);
    end else begin
      cur <= 16'h0000;
    end
  end

  assign sense_cmp_o  = (cur >= trip_level_i);
  assign ds_monitor_o = short_i;
endmodule

// ---- bench/current_limit_pwm_timing_tb.sv ----
// Self-checking bench for the current-limit PWM timing block
`timescale 1ns/1ps
// ====================
// Bench top
module current_limit_pwm_timing_tb;
  logic                      ref_clk;
  logic                      rst_b;
  logic                      pwm;
  logic                      fall;
  logic                      zcs;
  logic                      short_r;
  logic                      cmp;
  logic                      ds;
  clp_pkg::clp_ctl_mode_type mode;
  logic [4:0]                offc;
  logic [3:0]                thr;
  logic [3:0]                bcode;
  logic [3:0]                thr_o;
  logic [1:0]                rsel;
  logic [15:0]               level;
  logic                      drv;
  logic                      hi;
  logic                      lo;
  logic                      fa;
  logic                      lim;
  logic                      blk;
  logic                      dsf;
  int                        num_errors;
  int                        cmp_count;
  int                        n;
  int                        m;
  // Trip cases: select, emf falling, crossing seen, off code, blank code
  int rs_t[7] = '{1, 2, 3, 0, 0, 0, 0};
  int fl_t[7] = '{0, 0, 0, 1, 1, 0, 0};
  int zc_t[7] = '{0, 0, 0, 0, 1, 0, 1};
  int of_t[7] = '{0, 31, 19, 1, 2, 3, 22};
  int bt_t[7] = '{2, 0, 15, 11, 1, 3, 4};

  clp_current_limit dut_u (
    .ref_clk_i(ref_clk),
    .rst_b_i(rst_b),
    .control_mode_i(mode),
    .off_time_code_i(offc),
    .current_threshold_code_i(thr),
    .recirculation_select_i(rsel),
    .blank_time_code_i(bcode),
    .bemf_falling_i(fall),
    .zero_cross_seen_i(zcs),
    .pwm_in_i(pwm),
    .sense_cmp_i(cmp),
    .ds_monitor_i(ds),
    .current_limit_threshold_o(thr_o),
    .drive_o(drv),
    .recirc_high_side_o(hi),
    .recirc_low_side_o(lo),
    .fast_decay_o(fa),
    .limit_active_o(lim),
    .blank_o(blk),
    .ds_fault_o(dsf)
  );

  clp_bridge_model bridge_u (
    .ref_clk_i(ref_clk),
    .rst_b_i(rst_b),
    .drive_i(drv),
    .fast_decay_i(fa),
    .trip_level_i(level),
    .short_i(short_r),
    .sense_cmp_o(cmp),
    .ds_monitor_o(ds)
  );

  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ====================
  // Tasks
  task automatic step(input int k = 1);
    repeat (k) @(posedge ref_clk);
    #2;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Cycles an output holds: 0 limit, 1 blank, 2 drive, 3 not blank; bounded
  task automatic hold(input int s, output int c);
    c = 0;
    while ((s == 0 ? lim : s == 1 ? blk : s == 2 ? drv : !blk) === 1'h1) begin
      c++;
      step();
      if (c > 5000) begin
        num_errors++;
        summarize();
      end
    end
  endtask

  task automatic do_reset();
    rst_b = 1'h0;
    step(16);
    rst_b = 1'h1;
    step(2);
  endtask

  function automatic logic [2:0] exp_rc(input logic [1:0] s, input logic f, input logic z);
    logic h;
    h = f ? z : !z;
    case (s)
      clp_pkg::RECIRC_HIGH: exp_rc = 3'h4;
      clp_pkg::RECIRC_LOW:  exp_rc = 3'h2;
      clp_pkg::RECIRC_FAST: exp_rc = 3'h1;
      default:              exp_rc = {h, !h, 1'h0};
    endcase
  endfunction

  // ====================
  // Main sequence
  initial begin
    rst_b = 1'h0;
    pwm = 1'h0;
    fall = 1'h0;
    zcs = 1'h0;
    short_r = 1'h0;
    mode = clp_pkg::MODE_DIRECT;
    offc = 5'h00;
    thr = 4'h0;
    rsel = 2'h0;
    bcode = 4'h0;
    level = 16'hFFFF;
    num_errors = 0;
    cmp_count = 0;
    do_reset();
    for (int k = 0; k < 16; k++) begin
      thr = 4'(k);
      step(2);
      chk("thr code", thr_o, k);
    end
    pwm = 1'h1;
    step(4);
    chk("direct drive", drv, 1);
    pwm = 1'h0;
    step(4);
    chk("direct idle", drv, 0);
    $display("test code threshold and direct drive done");
    mode = clp_pkg::MODE_CURRENT;
    for (int h = 100; h <= 200; h += 100) begin
      repeat (4) begin
        pwm = 1'h1;
        step(h);
        pwm = 1'h0;
        step(250 - h);
      end
      chk("duty thr", thr_o, (256 * h / 250) / 16);
    end
    $display("test duty threshold done");
    // Low trip level: comparator goes high within a few cycles of each drive start
    level = 16'h0001;
    for (int i = 0; i < 7; i++) begin
      rsel = 2'(rs_t[i]);
      fall = 1'(fl_t[i]);
      zcs = 1'(zc_t[i]);
      offc = 5'(of_t[i]);
      bcode = 4'(bt_t[i]);
      do_reset();
      hold(2, n);
      chk("drive vs blank", n >= bcode * 16 && n <= bcode * 16 + 6, 1);
      chk("trip", lim, 1);
      chk("recirc", {hi, lo, fa}, exp_rc(rsel, fall, zcs));
      hold(0, n);
      chk("off time", n, (50 + 4 * offc) * 16);
      chk("redrive", drv, 1);
      hold(1, n);
      chk("blank time", n, bcode * 16);
    end
    $display("test trips done");
    offc = 5'h02;
    bcode = 4'h1;
    // Both fixed-frequency modes; first blank is cut short by the reset steps
    for (int i = 0; i < 2; i++) begin
      mode = (i == 0) ? clp_pkg::MODE_INDIRECT : clp_pkg::MODE_SPEED;
      level = 16'hFFFF;
      do_reset();
      hold(1, n);
      hold(3, m);
      hold(1, n);
      hold(3, m);
      chk("fixed period", n + m, 58 * 16);
      chk("fixed drive", drv, 1);
      // Trip inside a period: off-time equals the period
      level = 16'h0001;
      hold(2, n);
      chk("fixed trip", lim, 1);
      hold(0, n);
      chk("fixed off time", n, 58 * 16);
    end
    level = 16'hFFFF;
    $display("test fixed period done");
    // Blank of 64 cycles covers the model's settling
    mode = clp_pkg::MODE_CURRENT;
    bcode = 4'h4;
    short_r = 1'h1;
    do_reset();
    step(8);
    chk("ds masked", dsf, 0);
    step(64);
    chk("ds seen", dsf, 1);
    $display("test monitor blank done");
    summarize();
  end
endmodule
